// ===== verilog/wdu_pkg.sv
package wdu_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int OSC_FREQ_HZ = 128000;
    localparam int PCLK_FREQ_HZ = 10000000;
    localparam int TIMEOUT_MIN_MS = 16;
    localparam int TIMEOUT_MAX_MS = 8000;
    // shortest period in oscillator cycles, the base that each code doubles
    localparam int TIMEOUT_BASE_CYC = OSC_FREQ_HZ * TIMEOUT_MIN_MS / 1000;
    localparam int CNT_W = 20;
    localparam int SPAN_W = CNT_W + 1;
    localparam logic [3:0] PRESC_MAX = 4'h9;
    localparam logic [3:0] PRESC_RST = 4'h0;
    localparam logic [3:0] PRESC_HALF_SEC = 4'h5;
    localparam logic [CNT_W-1:0] LIMIT_HALF_SEC = 20'h0ffff;
    localparam logic [CNT_W-1:0] LIMIT_MIN = 20'h007ff;
    localparam logic [CNT_W-1:0] LIMIT_MAX = 20'hfffff;
    // change window in pclk cycles after the opening write
    localparam logic [2:0] CHG_WINDOW_CYC = 3'h4;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_CAUSE = 12'h004;
    localparam int BIT_IRQ_FLAG = 7;
    localparam int BIT_IRQ_EN = 6;
    localparam int BIT_PRESC3 = 5;
    localparam int BIT_CHG_EN = 4;
    localparam int BIT_RST_EN = 3;
    localparam int BIT_WD_RST_FLAG = 3;

    typedef struct packed {
        logic irq_flag;
        logic irq_en;
        logic change_en;
        logic reset_en;
        logic [3:0] presc;
    } wdu_ctrl_t;

    function automatic wdu_ctrl_t wdu_unpack(input logic [7:0] b);
        wdu_ctrl_t c;
        c.irq_flag = b[BIT_IRQ_FLAG];
        c.irq_en = b[BIT_IRQ_EN];
        c.change_en = b[BIT_CHG_EN];
        c.reset_en = b[BIT_RST_EN];
        c.presc = {b[BIT_PRESC3], b[2:0]};
        return c;
    endfunction : wdu_unpack

    function automatic logic [7:0] wdu_pack(input wdu_ctrl_t c);
        logic [7:0] b;
        b = 8'h00;
        b[BIT_IRQ_FLAG] = c.irq_flag;
        b[BIT_IRQ_EN] = c.irq_en;
        b[BIT_CHG_EN] = c.change_en;
        b[BIT_RST_EN] = c.reset_en;
        b[BIT_PRESC3] = c.presc[3];
        b[2:0] = c.presc[2:0];
        return b;
    endfunction : wdu_pack

endpackage : wdu_pkg

// ===== verilog/wdu_timer.sv
`timescale 1ns/1ps
module wdu_timer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic tick,
    input wire logic run,
    input wire logic restart,
    input wire logic [3:0] presc,
    // result
    output logic expire_q
);

    logic [wdu_pkg::CNT_W-1:0] cnt_q;
    logic [3:0] sel;
    logic [wdu_pkg::SPAN_W-1:0] span;
    logic [wdu_pkg::SPAN_W-1:0] span_m1;
    logic [wdu_pkg::CNT_W-1:0] limit;
    logic hit;

    // ------------------------------------------------------------------
    // time-out selection
    // ------------------------------------------------------------------
    // reserved codes run at the longest period rather than something shorter
    assign sel = (presc > wdu_pkg::PRESC_MAX) ? wdu_pkg::PRESC_MAX : presc;
    assign span = wdu_pkg::SPAN_W'(wdu_pkg::TIMEOUT_BASE_CYC) << sel;
    assign span_m1 = span - wdu_pkg::SPAN_W'(1);
    assign limit = span_m1[wdu_pkg::CNT_W-1:0];
    // >= so that moving to a shorter period expires at once, never wraps
    assign hit = tick && (cnt_q >= limit);

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (!run || restart) begin
            cnt_q <= '0;
        end else if (hit) begin
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= cnt_q + wdu_pkg::CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expire_q <= 1'b0;
        end else begin
            expire_q <= run && !restart && hit;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_RESTART_CLEARS: assert property (restart |=> cnt_q == '0 && !expire_q)
        else $error("restart did not return counter to start");
    AST_HALF_SEC: assert property (sel == wdu_pkg::PRESC_HALF_SEC |-> limit == wdu_pkg::LIMIT_HALF_SEC)
        else $error("code 0101 does not select 64K cycles");
    AST_RANGE: assert property ((sel == wdu_pkg::PRESC_RST |-> limit == wdu_pkg::LIMIT_MIN)
                                and (presc >= wdu_pkg::PRESC_MAX |-> limit == wdu_pkg::LIMIT_MAX))
        else $error("time-out range ends wrong");
    AST_EXPIRE_CAUSE: assert property (expire_q |-> $past(tick) && $past(cnt_q) >= $past(limit))
        else $error("expiry without count reaching limit");
    AST_NO_EARLY: assert property (run && !restart && tick && cnt_q < limit |=> !expire_q
                                   && cnt_q == $past(cnt_q) + wdu_pkg::CNT_W'(1))
        else $error("counter did not advance on tick");

endmodule : wdu_timer

// ===== verilog/wdu_top.sv
// What this block does
// - counter advances on ticks of the separate slow oscillator, not the bus clock
// - on reaching the selected limit, give interrupt or system reset by mode
// - restart instruction returns counter to zero; software restarts before limit
// - interrupt-only mode raises the time-out interrupt, usable as sleep wake-up
// - reset-only mode pulses the system reset on expiry
// - combined mode: first expiry interrupts, a later unserviced one resets
// - always-on fuse forces reset enable to one and interrupt enable to zero
// - clearing reset enable or changing prescale only through the timed sequence
// - the new settings write is taken only within four cycles of opening
// - time-out selectable from about 16 ms up to about 8 s
// - watchdog stays enabled after the reset it caused
// - prescale code 0101 selects 64K oscillator cycles, about half a second
// - while the watchdog reset flag is set, reset enable reads and stays one
// - time-out in interrupt mode sets flag; vector or write of one clears
// - in combined mode the vector clears interrupt enable and flag together
`timescale 1ns/1ps
module wdu_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wdu_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core side
    input wire logic restart_i,
    input wire logic irq_ack_i,
    // pins and fuse
    input wire logic osc_clk_i,
    input wire logic always_on_fuse_i,
    // results
    output logic timeout_irq_o,
    output logic sys_reset_o
);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;
    logic fuse_s1_q;
    logic fuse_q;
    logic osc_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_clk_i;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    // the fuse is static, but it is still a pin and must not reach logic raw
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_s1_q <= 1'b0;
            fuse_q <= 1'b0;
        end else begin
            fuse_s1_q <= always_on_fuse_i;
            fuse_q <= fuse_s1_q;
        end
    end

    // one tick per oscillator rising edge; needs pclk well above the oscillator
    assign osc_tick = osc_s2_q && !osc_s3_q;

    // ------------------------------------------------------------------
    // apb access
    // ------------------------------------------------------------------
    logic access;
    logic wr_ctrl;
    logic wr_cause;
    logic mapped;
    wdu_pkg::wdu_ctrl_t wdat;
    wdu_pkg::wdu_ctrl_t ctrl_rd;
    logic [2:0] win_q;
    logic win_open;
    logic open_seq;
    logic accept_seq;
    logic reset_en_q;
    logic irq_en_q;
    logic irq_flag_q;
    logic [3:0] presc_q;
    logic wd_rst_flag_q;
    logic expire;

    // one wait state: data is registered, then pready rises
    assign access = psel && penable && pready;
    assign mapped = (paddr == wdu_pkg::ADDR_CTRL) || (paddr == wdu_pkg::ADDR_CAUSE);
    assign wr_ctrl = access && pwrite && pstrb[0] && (paddr == wdu_pkg::ADDR_CTRL);
    assign wr_cause = access && pwrite && pstrb[0] && (paddr == wdu_pkg::ADDR_CAUSE);
    assign wdat = wdu_pkg::wdu_unpack(pwdata[7:0]);
    assign win_open = (win_q != 3'h0);
    assign open_seq = wr_ctrl && wdat.change_en && wdat.reset_en;
    assign accept_seq = wr_ctrl && win_open && !wdat.change_en;

    always_comb begin
        ctrl_rd.irq_flag = irq_flag_q;
        ctrl_rd.irq_en = irq_en_q;
        ctrl_rd.change_en = win_open;
        ctrl_rd.reset_en = reset_en_q;
        ctrl_rd.presc = presc_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            if (pwrite || !mapped) begin
                prdata <= 32'h0000_0000;
            end else if (paddr == wdu_pkg::ADDR_CTRL) begin
                prdata <= {24'h00_0000, wdu_pkg::wdu_pack(ctrl_rd)};
            end else begin
                prdata <= 32'(wd_rst_flag_q) << wdu_pkg::BIT_WD_RST_FLAG;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // timed change window
    // ------------------------------------------------------------------
    // hardware drops change enable by itself once the window has run out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_q <= 3'h0;
        end else if (open_seq) begin
            win_q <= wdu_pkg::CHG_WINDOW_CYC;
        end else if (accept_seq) begin
            win_q <= 3'h0;
        end else if (win_open) begin
            win_q <= win_q - 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    logic irq_event;
    logic rst_event;

    // combined mode resets only if the earlier interrupt went unserviced
    always_comb begin
        irq_event = 1'b0;
        rst_event = 1'b0;
        if (expire) begin
            if (irq_en_q && !reset_en_q) begin
                irq_event = 1'b1;
            end else if (!irq_en_q && reset_en_q) begin
                rst_event = 1'b1;
            end else if (irq_en_q && reset_en_q) begin
                irq_event = !irq_flag_q;
                rst_event = irq_flag_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_en_q <= 1'b0;
        end else if (fuse_q || wd_rst_flag_q || rst_event) begin
            reset_en_q <= 1'b1;
        end else if (accept_seq) begin
            reset_en_q <= wdat.reset_en;
        end else if (wr_ctrl && wdat.reset_en) begin
            reset_en_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= wdu_pkg::PRESC_RST;
        end else if (accept_seq) begin
            presc_q <= wdat.presc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= 1'b0;
        end else if (fuse_q) begin
            irq_en_q <= 1'b0;
        end else if (irq_ack_i && reset_en_q) begin
            irq_en_q <= 1'b0;
        end else if (wr_ctrl) begin
            irq_en_q <= wdat.irq_en;
        end
    end

    // a time-out in the same cycle as a clear keeps the flag set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag_q <= 1'b0;
        end else if (irq_event) begin
            irq_flag_q <= 1'b1;
        end else if (irq_ack_i || (wr_ctrl && wdat.irq_flag)) begin
            irq_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // reset cause and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_rst_flag_q <= 1'b0;
        end else if (rst_event) begin
            wd_rst_flag_q <= 1'b1;
        end else if (wr_cause && !pwdata[wdu_pkg::BIT_WD_RST_FLAG]) begin
            wd_rst_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset_o <= 1'b0;
            timeout_irq_o <= 1'b0;
        end else begin
            sys_reset_o <= rst_event;
            timeout_irq_o <= (irq_flag_q || irq_event) && irq_en_q;
        end
    end

    wdu_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tick(osc_tick),
        .run(reset_en_q || irq_en_q),
        .restart(restart_i),
        .presc(presc_q),
        .expire_q(expire)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_TICK_SYNCED: assert property (osc_tick |-> $past(osc_clk_i, 2) && !$past(osc_clk_i, 3))
        else $error("oscillator tick not from synchronised edge");
    AST_IRQ_ONLY: assert property (expire && irq_en_q && !reset_en_q |=> irq_flag_q && !sys_reset_o)
        else $error("interrupt mode expiry did not set flag");
    AST_RESET_ONLY: assert property (expire && !irq_en_q && reset_en_q |=> sys_reset_o ##1 !sys_reset_o)
        else $error("reset mode expiry did not pulse reset");
    AST_COMBINED: assert property (expire && irq_en_q && reset_en_q && !irq_ack_i |=> sys_reset_o == $past(irq_flag_q)
                                   && irq_flag_q)
        else $error("combined mode order wrong");
    AST_FUSE_LOCK: assert property (fuse_q |=> reset_en_q && !irq_en_q)
        else $error("fuse did not lock mode bits");
    AST_LOCKED: assert property (wr_ctrl && !win_open |=> $stable(presc_q) && (reset_en_q || !$past(reset_en_q)))
        else $error("locked setting changed without sequence");
    AST_WINDOW: assert property (open_seq ##1 (!wr_ctrl)[*4] |=> !win_open)
        else $error("change window longer than four cycles");
    AST_ACCEPT: assert property (accept_seq && !fuse_q && !wd_rst_flag_q && !rst_event |=>
                                 presc_q == $past(wdat.presc) && reset_en_q == $past(wdat.reset_en))
        else $error("write inside window not taken");
    AST_AFTER_RESET: assert property (sys_reset_o |-> wd_rst_flag_q ##1 reset_en_q)
        else $error("watchdog not kept enabled after its reset");
    AST_FLAG_HOLDS_EN: assert property (wd_rst_flag_q |=> reset_en_q)
        else $error("reset enable cleared while reset flag set");
    AST_W1C: assert property (wr_ctrl && wdat.irq_flag && !irq_event |=> !irq_flag_q)
        else $error("write of one did not clear flag");
    AST_VECTOR: assert property (irq_ack_i && reset_en_q && !fuse_q && !irq_event |=> !irq_en_q && !irq_flag_q)
        else $error("vector did not return to reset mode");

    COV_IRQ: cover property (irq_event);
    COV_RESET: cover property (rst_event);
    COV_SEQ: cover property (open_seq ##[1:4] accept_seq);
    COV_COMBINED: cover property (irq_event && reset_en_q ##[1:300] irq_ack_i);

endmodule : wdu_top

// ===== dv/wdu_core_model.sv
`timescale 1ns/1ps
module wdu_core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench control
    input wire logic restart_req,
    input wire logic ack_en,
    input wire logic [3:0] ack_dly,
    // watchdog side
    input wire logic irq,
    output logic restart,
    output logic vec_ack
);
    // ------------------------------------------------------------------
    // restart instruction and vector entry
    // ------------------------------------------------------------------
    logic [4:0] wait_q;
    logic busy_q;

    // one-cycle pulse, launched on the core clock like a real instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart <= 1'b0;
        end else begin
            restart <= restart_req;
        end
    end

    // one vector entry per request, after a variable latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            wait_q <= 5'h00;
            vec_ack <= 1'b0;
        end else begin
            vec_ack <= 1'b0;
            if (!irq) begin
                busy_q <= 1'b0;
            end else if (ack_en && !busy_q) begin
                if (wait_q == {1'b0, ack_dly}) begin
                    vec_ack <= 1'b1;
                    busy_q <= 1'b1;
                    wait_q <= 5'h00;
                end else begin
                    wait_q <= wait_q + 5'h01;
                end
            end
        end
    end
endmodule : wdu_core_model

// ===== dv/wdu_top_tb_top.sv
`timescale 1ns/1ps
module wdu_top_tb_top;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic restart_i;
    logic irq_ack_i;
    logic osc_clk_i = 1'b0;
    logic always_on_fuse_i = 1'b0;
    logic timeout_irq_o;
    logic sys_reset_o;
    logic restart_req = 1'b0;
    logic ack_en = 1'b0;
    logic [3:0] ack_dly = 4'h0;
    logic [2:0] osc_div = 3'h0;
    logic [31:0] ticks_seen = 32'h00000000;
    logic irq_prev = 1'b0;
    logic [7:0] lfsr_q = 8'h36;
    logic [32:0] rdq[$];
    logic [33:0] evq[$];
    int err_total = 0;
    int checks_done = 0;

    always #50 pclk = ~pclk;

    wdu_top u_wdu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .restart_i(restart_i), .irq_ack_i(irq_ack_i), .osc_clk_i(osc_clk_i),
        .always_on_fuse_i(always_on_fuse_i), .timeout_irq_o(timeout_irq_o), .sys_reset_o(sys_reset_o));

    wdu_core_model u_wdu_core_model (.pclk(pclk), .presetn(presetn), .restart_req(restart_req),
        .ack_en(ack_en), .ack_dly(ack_dly), .irq(timeout_irq_o), .restart(restart_i), .vec_ack(irq_ack_i));

    // ------------------------------------------------------------------
    // slow oscillator: one tick every 8 pclk, counted from each restart
    // ------------------------------------------------------------------
    always @(posedge pclk) begin
        osc_div <= osc_div + 3'h1;
        osc_clk_i <= osc_div[2];
        if (restart_i === 1'b1) begin
            ticks_seen <= 32'h00000000;
        end else if (osc_div == 3'h4) begin
            ticks_seen <= ticks_seen + 32'h00000001;
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        int n;
        logic ok;
        lfsr_q = lfsr_next(lfsr_q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {lfsr_q, lfsr_q, lfsr_q, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        ok = 1'b0;
        while (!ok && n < 20) begin
            @(posedge pclk);
            ok = (pready === 1'b1);
            n++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) begin
            err_total++;
            summarize();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'h1);
    endtask : wr

    // the note goes in before the request so the watcher always finds it
    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic err);
        rdq.push_back({err, 24'h000000, exp});
        apb(1'b0, a, 8'h00, 4'h0);
    endtask : rd

    // restart well clear of the synchronised tick so the count is exact
    task automatic do_restart;
        while (osc_div != 3'h7) @(posedge pclk);
        restart_req <= 1'b1;
        @(posedge pclk);
        restart_req <= 1'b0;
    endtask : do_restart

    task automatic wait_events;
        int n;
        for (n = 0; n < 40000 && evq.size() != 0; n++) @(posedge pclk);
        if (evq.size() != 0) begin
            err_total++;
            summarize();
        end
    endtask : wait_events

    task automatic take_event(input logic [1:0] kind);
        logic [33:0] e;
        if (evq.size() == 0) begin
            check("unexpected event", {32'h00000000, kind}, 34'h000000000);
        end else begin
            e = evq.pop_front();
            check("event kind", {32'h00000000, kind}, {32'h00000000, e[33:32]});
            if (e[31:0] != 32'h00000000) check("event ticks", {2'h0, ticks_seen}, {2'h0, e[31:0]});
        end
    endtask : take_event

    // ------------------------------------------------------------------
    // watcher: read data, irq rising edges and reset pulses
    // ------------------------------------------------------------------
    always @(posedge pclk) begin
        if (presetn === 1'b1) begin
            if (psel && penable && !pwrite && pready === 1'b1) begin
                if (rdq.size() == 0) check("unexpected read", 34'h000000001, 34'h000000000);
                else check("read word", {1'b0, pslverr, prdata}, {1'b0, rdq.pop_front()});
            end
            if (sys_reset_o === 1'b1) take_event(2'h2);
            if (timeout_irq_o === 1'b1 && irq_prev === 1'b0) take_event(2'h1);
        end
        irq_prev = timeout_irq_o;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(wdu_pkg::ADDR_CTRL, 8'h00, 1'b0);
        rd(wdu_pkg::ADDR_CAUSE, 8'h00, 1'b0);
        rd(12'h008, 8'h00, 1'b1);
        apb(1'b1, wdu_pkg::ADDR_CTRL, 8'h08, 4'h0);
        rd(wdu_pkg::ADDR_CTRL, 8'h00, 1'b0);
        wr(wdu_pkg::ADDR_CTRL, 8'h09);
        rd(wdu_pkg::ADDR_CTRL, 8'h08, 1'b0);
        wr(wdu_pkg::ADDR_CTRL, 8'h00);
        rd(wdu_pkg::ADDR_CTRL, 8'h08, 1'b0);
        wr(wdu_pkg::ADDR_CTRL, 8'h18);
        wr(wdu_pkg::ADDR_CTRL, 8'h01);
        rd(wdu_pkg::ADDR_CTRL, 8'h01, 1'b0);
        wr(wdu_pkg::ADDR_CTRL, 8'h19);
        repeat (6) @(posedge pclk);
        wr(wdu_pkg::ADDR_CTRL, 8'h00);
        rd(wdu_pkg::ADDR_CTRL, 8'h09, 1'b0);
        wr(wdu_pkg::ADDR_CTRL, 8'h19);
        wr(wdu_pkg::ADDR_CTRL, 8'h08);
        rd(wdu_pkg::ADDR_CTRL, 8'h08, 1'b0);
        // reset-only mode, shortest period
        do_restart();
        evq.push_back({2'h2, 32'h00000800});
        wait_events();
        rd(wdu_pkg::ADDR_CAUSE, 8'h08, 1'b0);
        rd(wdu_pkg::ADDR_CTRL, 8'h08, 1'b0);
        wr(wdu_pkg::ADDR_CTRL, 8'h18);
        wr(wdu_pkg::ADDR_CTRL, 8'h00);
        rd(wdu_pkg::ADDR_CTRL, 8'h08, 1'b0);
        wr(wdu_pkg::ADDR_CAUSE, 8'h00);
        rd(wdu_pkg::ADDR_CAUSE, 8'h00, 1'b0);
        // interrupt-only mode, next code doubles the period
        wr(wdu_pkg::ADDR_CTRL, 8'h18);
        wr(wdu_pkg::ADDR_CTRL, 8'h41);
        rd(wdu_pkg::ADDR_CTRL, 8'h41, 1'b0);
        do_restart();
        evq.push_back({2'h1, 32'h00001000});
        wait_events();
        rd(wdu_pkg::ADDR_CTRL, 8'hc1, 1'b0);
        wr(wdu_pkg::ADDR_CTRL, 8'hc1);
        rd(wdu_pkg::ADDR_CTRL, 8'h41, 1'b0);
        check("irq line", {33'h000000000, timeout_irq_o}, 34'h000000000);
        // combined mode: vector entry drops to reset-only, next expiry resets
        wr(wdu_pkg::ADDR_CTRL, 8'h19);
        wr(wdu_pkg::ADDR_CTRL, 8'h48);
        lfsr_q = lfsr_next(lfsr_q);
        ack_dly <= lfsr_q[3:0];
        ack_en <= 1'b1;
        do_restart();
        evq.push_back({2'h1, 32'h00000800});
        evq.push_back({2'h2, 32'h00000000});
        wait_events();
        rd(wdu_pkg::ADDR_CTRL, 8'h08, 1'b0);
        // fuse forces reset-only mode against a legal sequence
        wr(wdu_pkg::ADDR_CAUSE, 8'h00);
        always_on_fuse_i <= 1'b1;
        repeat (4) @(posedge pclk);
        wr(wdu_pkg::ADDR_CTRL, 8'h18);
        wr(wdu_pkg::ADDR_CTRL, 8'h40);
        rd(wdu_pkg::ADDR_CTRL, 8'h08, 1'b0);
        repeat (4) @(posedge pclk);
        summarize();
    end
endmodule : wdu_top_tb_top
